// file: bench/upbm_mapper_model.sv
// Symbol mapper and frame timing model feeding the staging input
`timescale 1ns/1ps
`default_nettype none
module upbm_mapper_model (
  // Clock
  input wire logic pclk,
  // Stream and frame timing towards staging
  output var upbm_pkg::upbm_sc_in_type sc_in,
  output var logic frame_boundary_strobe
);
  // ----------------------------------------
  // Drivers, all changed just after a rising edge
  // ----------------------------------------
  initial begin
    sc_in = '0;
    frame_boundary_strobe = 1'b0;
  end
  // One subcarrier per call, link span chosen by the caller
  task automatic put_sc(input upbm_pkg::upbm_sc_in_type v);
    @(posedge pclk);
    sc_in <= v;
  endtask : put_sc
  // Gap: side bits flip so stale values are never trusted
  task automatic idle();
    @(posedge pclk);
    sc_in <= {1'b0, ~sc_in[3:0]};
  endtask : idle
  // Strobe held for several cycles must still count once
  task automatic strobe(input int hold);
    @(posedge pclk);
    frame_boundary_strobe <= 1'b1;
    repeat (hold) @(posedge pclk);
    frame_boundary_strobe <= 1'b0;
  endtask : strobe
endmodule : upbm_mapper_model
`default_nettype wire

// file: bench/upbm_top_tb.sv
// Self-checking bench for the pilot and burst marker block
`timescale 1ns/1ps
`default_nettype none
module upbm_top_tb;
  // ----------------------------------------
  // Signals, queues and counters
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mark_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, cfg;
  logic frame_boundary_strobe, frame_handoff, transmit_enable_request;
  logic mark_busy, mark_valid, mark_ref, mark_boost, tx_last;
  logic [1:0] mark_phase;
  logic [3:0] gen [5];
  upbm_pkg::upbm_sc_in_type sc_in;
  upbm_pkg::upbm_sc_out_type sc_out;
  upbm_pkg::upbm_mark_req_type mark_cmd, cmd;
  upbm_pkg::upbm_sc_out_type q_sc[$];
  logic q_tx[$];
  logic [3:0] q_mk[$];
  int mismatches, checked, seed;

  // Clock at 50 MHz
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  upbm_mapper_model mapper (.pclk(pclk), .sc_in(sc_in),
    .frame_boundary_strobe(frame_boundary_strobe));
  upbm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sc_in(sc_in),
    .frame_boundary_strobe(frame_boundary_strobe), .sc_out(sc_out),
    .frame_handoff(frame_handoff), .mark_req(mark_req),
    .transmit_enable_request(transmit_enable_request),
    .mark_cmd(mark_cmd), .mark_busy(mark_busy), .mark_valid(mark_valid),
    .mark_ref(mark_ref), .mark_boost(mark_boost), .mark_phase(mark_phase));

  // ----------------------------------------
  // Comparison and closing
  // ----------------------------------------
  task automatic note(input logic bad, input logic [31:0] got, exp);
    checked++;
    if (bad) begin
      mismatches++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask : note
  task automatic cmp_w(input logic [31:0] got, exp);
    note(got !== exp, got, exp);
  endtask : cmp_w
  // Sign of a pilot only matters where a pilot sits
  task automatic cmp_sc(input upbm_pkg::upbm_sc_out_type g, e);
    if (e.pilot_mask === 16'h0000) begin
      g.pilot_neg = 1'b0;
      e.pilot_neg = 1'b0;
    end
    note(g !== e, 32'(g), 32'(e));
  endtask : cmp_sc
  task automatic cmp_mk(input logic [3:0] g, e);
    note(g !== e, {28'h000_0000, g}, {28'h000_0000, e});
  endtask : cmp_mk
  task automatic end_of_test();
    mismatches += q_sc.size() + q_tx.size() + q_mk.size();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Hang guard, well inside 100k cycles
  initial begin
    #1_000_000;
    mismatches++;
    end_of_test();
  end

  // Output watcher takes the oldest note for each result
  always @(negedge pclk) begin
    if (sc_out.valid === 1'b1) begin
      if (q_sc.size() > 0) cmp_sc(sc_out, q_sc.pop_front());
      else note(1'b1, 32'(sc_out), '0);
    end
    if (frame_handoff === 1'b1) begin
      if (q_tx.size() > 0) cmp_w(32'(transmit_enable_request), 32'(q_tx.pop_front()));
      else note(1'b1, 32'h0000_0001, '0);
    end
    if (mark_valid === 1'b1) begin
      if (q_mk.size() > 0) cmp_mk({mark_ref, mark_boost, mark_phase}, q_mk.pop_front());
      else note(1'b1, 32'h0000_0001, '0);
    end
  end

  // ----------------------------------------
  // Reference arithmetic and drivers
  // ----------------------------------------
  function automatic logic [3:0] gmul(input logic [3:0] a, b);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) p ^= a;
      a = {a[2:0], 1'b0} ^ (a[3] ? 4'h3 : 4'h0);
    end
    return p;
  endfunction : gmul
  // Period is half of 1 << code, so code 0 never divides by zero
  function automatic logic hit(input logic [3:0] s, input logic [2:0] c,
                               input int k);
    int per;
    per = 1 << c;
    return c != 3'h0 && c <= 3'h5 && k >= s && (2 * (k - s)) % per == 0;
  endfunction : hit
  task automatic build_gen();
    logic [3:0] r;
    gen = '{4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
    r = 4'h1;
    for (int j = 0; j < 4; j++) begin
      for (int i = 4; i > 0; i--) gen[i] = gen[i-1] ^ gmul(gen[i], r);
      gen[0] = gmul(gen[0], r);
      r = gmul(r, 4'h2);
    end
  endtask : build_gen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, exp, input logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Answer and read data are taken at the edge that sees pready high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    if (!w) cmp_w(prdata, exp);
    cmp_w(32'(pslverr), 32'(err));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic frame(input logic [31:0] c, input logic lk);
    upbm_pkg::upbm_sc_in_type v;
    upbm_pkg::upbm_sc_out_type e;
    logic [11:0] st;
    logic any;
    st = 12'hBFF;
    any = 1'b0;
    for (int k = 0; k < 40; k++) begin
      rnd = $random(seed);
      v.valid = 1'b1;
      v.first = (k == 0);
      v.burst = rnd[0];
      v.link = lk && k >= 8 && k < 16;
      v.excluded = !v.link && rnd[3:1] == 3'h0;
      e.valid = 1'b1;
      e.first = v.first;
      e.kind = v.excluded ? 3'h3 : v.link ? 3'h4 :
        hit(c[11:8], c[14:12], k) ? 3'h2 : hit(c[3:0], c[6:4], k) ? 3'h1 : 3'h0;
      e.pilot_mask = (e.kind == 3'h4 || v.burst && (e.kind == 3'h1 ||
        e.kind == 3'h2)) ? 16'h0005 : 16'h0000;
      if (v.burst && e.kind == 3'h2) e.pilot_mask |= c[16] ? 16'hA000 : 16'h00A0;
      e.pilot_neg = st[11];
      st = {st[10:0], st[11] ^ st[8] ^ st[7] ^ st[4]};
      any |= (e.pilot_mask != 16'h0000);
      q_sc.push_back(e);
      mapper.put_sc(v);
    end
    mapper.idle();
    q_tx.push_back(any);
    tx_last = any;
    mapper.strobe(3);
    repeat (3) @(posedge pclk);
    apb(1'b0, 12'h004, '0, 32'(any), 1'b0);
  endtask : frame
  // Reference element, then info high first, then P4..P1, high pair first
  task automatic mk_expect(input upbm_pkg::upbm_mark_req_type c);
    logic [3:0] s [7];
    logic [3:0] r [4];
    logic [3:0] fb;
    logic [1:0] ph;
    int n;
    n = c.rb16 ? 3 : 2;
    s[0] = c.stop ? 4'h0 : 4'hF;
    s[1] = c.stop ? c.last_element : 4'hF;
    s[2] = c.stop ? c.fill_bit : 4'hF;
    r = '{4'h0, 4'h0, 4'h0, 4'h0};
    for (int i = 3 - n; i < 3; i++) begin
      fb = s[i] ^ r[3];
      for (int j = 3; j > 0; j--) r[j] = r[j-1] ^ gmul(fb, gen[j]);
      r[0] = gmul(fb, gen[0]);
    end
    for (int j = 0; j < 4; j++) s[3+j] = r[3-j];
    ph = 2'd3;
    q_mk.push_back({2'b11, ph});
    for (int i = 3 - n; i < 7; i++) begin
      ph += s[i][3:2];
      q_mk.push_back({2'b01, ph});
      ph += s[i][1:0];
      q_mk.push_back({2'b01, ph});
    end
  endtask : mk_expect

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 76972;
    mismatches = 0;
    checked = 0;
    {presetn, psel, penable, pwrite, mark_req} = 5'h00;
    paddr = 12'h000;
    pwdata = '0;
    mark_cmd = '0;
    build_gen();
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, '0, '0, 1'b0);
    apb(1'b0, 12'h008, '0, '0, 1'b1);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF, '0, 1'b1);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF, '0, 1'b0);
    apb(1'b0, 12'h004, '0, '0, 1'b0);
    apb(1'b0, 12'h000, '0, '0, 1'b0);
    $display("register test done");
    // Every spacing code on both patterns, reserved bits written as junk
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      cfg = '0;
      cfg[3:0] = rnd[3:0];
      cfg[6:4] = 3'(i);
      cfg[11:8] = rnd[7:4];
      cfg[14:12] = 3'(7 - i);
      cfg[16] = rnd[8];
      apb(1'b1, 12'h000, cfg | (rnd & 32'hFFFE_8080), '0, 1'b0);
      apb(1'b0, 12'h000, '0, cfg, 1'b0);
      frame(cfg, rnd[9] | i[0]);
      $display("frame test %0d done", i);
    end
    // Start and stop, both block sizes, back to back, one stray request
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      cmd.stop = i[1];
      cmd.rb16 = i[0];
      cmd.fill_bit = rnd[3:0];
      cmd.last_element = rnd[7:4];
      mk_expect(cmd);
      @(posedge pclk);
      mark_req <= 1'b1;
      mark_cmd <= cmd;
      @(posedge pclk);
      mark_req <= 1'b0;
      mark_cmd <= ~cmd;
      repeat (3) @(posedge pclk);
      mark_req <= 1'b1;
      @(posedge pclk);
      mark_req <= 1'b0;
      apb(1'b0, 12'h004, '0, {30'h0, 1'b1, tx_last}, 1'b0);
      for (int n = 0; mark_busy !== 1'b0; n++) begin
        @(negedge pclk);
        if (n > 100) begin
          mismatches++;
          end_of_test();
        end
      end
      $display("marker test %0d done", i);
    end
    repeat (20) @(posedge pclk);
    end_of_test();
  end
endmodule : upbm_top_tb
`default_nettype wire

// file: rtl/upbm_pkg.sv
// Shared constants and carrier types for the pilot and burst marker block
package upbm_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] CFG_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  localparam int PRI_START_LSB = 0;
  localparam int PRI_CODE_LSB = 4;
  localparam int SEC_START_LSB = 8;
  localparam int SEC_CODE_LSB = 12;
  localparam int RB16_BIT = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // ----------------------------------------
  // Pilot sequence and spacing codes
  // ----------------------------------------
  localparam logic [11:0] PRBS_SEED = 12'hBFF;
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] CODE_MAX = 3'h5;
  // ----------------------------------------
  // Block kinds
  // ----------------------------------------
  localparam logic [2:0] KIND_DATA = 3'h0;
  localparam logic [2:0] KIND_PRI = 3'h1;
  localparam logic [2:0] KIND_SEC = 3'h2;
  localparam logic [2:0] KIND_EXCL = 3'h3;
  localparam logic [2:0] LINK_FRAME_TAG = 3'h4;
  // ----------------------------------------
  // Marker coding
  // ----------------------------------------
  localparam logic [1:0] REF_DIBIT = 2'h3;
  localparam logic [3:0] INFO_ONES = 4'hF;
  localparam logic [3:0] PAD_SYM = 4'h0;
  localparam logic [3:0] GEN_C3 = 4'hF;
  localparam logic [3:0] GEN_C2 = 4'h3;
  localparam logic [3:0] GEN_C1 = 4'h1;
  localparam logic [3:0] GEN_C0 = 4'hC;
  localparam logic [4:0] DIBITS_RB8 = 5'd12;
  localparam logic [4:0] DIBITS_RB16 = 5'd14;

  // Subcarrier from the symbol mapper
  typedef struct packed {
    logic valid;
    logic first;
    logic burst;
    logic link;
    logic excluded;
  } upbm_sc_in_type;

  // Staged subcarrier towards the IDFT
  typedef struct packed {
    logic valid;
    logic first;
    logic [2:0] kind;
    logic pilot_neg;
    logic [15:0] pilot_mask;
  } upbm_sc_out_type;

  // Marker request
  typedef struct packed {
    logic stop;
    logic rb16;
    logic [3:0] fill_bit;
    logic [3:0] last_element;
  } upbm_mark_req_type;

  typedef enum logic [2:0] {
    MK_IDLE = 3'b001,
    MK_REF = 3'b010,
    MK_DATA = 3'b100
  } upbm_mark_state_type;
endpackage : upbm_pkg

// file: rtl/upbm_top.sv
// Pilot insertion, frame staging and burst marker encoding
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module upbm_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mapper stream and frame timing
  input wire upbm_pkg::upbm_sc_in_type sc_in,
  input wire logic frame_boundary_strobe,
  // Staged stream to the IDFT
  output upbm_pkg::upbm_sc_out_type sc_out,
  output logic frame_handoff,
  output logic transmit_enable_request,
  // Burst marker
  input wire logic mark_req,
  input wire upbm_pkg::upbm_mark_req_type mark_cmd,
  output logic mark_busy,
  output logic mark_valid,
  output logic mark_ref,
  output logic mark_boost,
  output logic [1:0] mark_phase
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // GF(16) multiply reduced by x^4 + x + 1
  function automatic logic [3:0] gf_mul(input logic [3:0] a,
                                        input logic [3:0] b);
    logic [3:0] p;
    logic [3:0] t;
    p = 4'h0;
    t = a;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        p = p ^ t;
      end
      t = {t[2:0], 1'b0} ^ (t[3] ? 4'h3 : 4'h0);
    end
    return p;
  endfunction : gf_mul

  // Systematic parity, info highest first, P4 in [15:12]
  function automatic logic [15:0] rs_parity(input logic [11:0] info,
                                            input logic rb16);
    logic [3:0] r3;
    logic [3:0] r2;
    logic [3:0] r1;
    logic [3:0] r0;
    logic [3:0] fb;
    r3 = 4'h0;
    r2 = 4'h0;
    r1 = 4'h0;
    r0 = 4'h0;
    for (int i = 2; i >= 0; i--) begin
      if (rb16 || i < 2) begin
        fb = info[i*4 +: 4] ^ r3;
        r3 = r2 ^ gf_mul(fb, upbm_pkg::GEN_C3);
        r2 = r1 ^ gf_mul(fb, upbm_pkg::GEN_C2);
        r1 = r0 ^ gf_mul(fb, upbm_pkg::GEN_C1);
        r0 = gf_mul(fb, upbm_pkg::GEN_C0);
      end
    end
    return {r3, r2, r1, r0};
  endfunction : rs_parity

  // Pattern membership for subcarrier k
  function automatic logic pat_hit(input logic [11:0] k,
                                   input logic [3:0] start,
                                   input logic [2:0] code);
    logic [11:0] d;
    logic [3:0] m;
    d = k - {8'h00, start};
    m = 4'h0;
    unique case (code)
      3'h2: m = 4'h1;
      3'h3: m = 4'h3;
      3'h4: m = 4'h7;
      3'h5: m = 4'hF;
      default: m = 4'h0;
    endcase
    return (code != upbm_pkg::CODE_OFF) && (code <= upbm_pkg::CODE_MAX)
      && (k >= {8'h00, start}) && ((d[3:0] & m) == 4'h0);
  endfunction : pat_hit

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [31:0] cfg_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic tx_en_ff;
  logic mark_busy_ff;

  wire setup_cyc = psel & ~penable;
  wire hit_cfg = paddr == upbm_pkg::CFG_ADDR;
  wire hit_stat = paddr == upbm_pkg::STAT_ADDR;
  wire wr_cfg = psel & penable & pready_ff & pwrite & hit_cfg;
  wire [3:0] pri_start = cfg_ff[upbm_pkg::PRI_START_LSB +: 4];
  wire [2:0] pri_code = cfg_ff[upbm_pkg::PRI_CODE_LSB +: 3];
  wire [3:0] sec_start = cfg_ff[upbm_pkg::SEC_START_LSB +: 4];
  wire [2:0] sec_code = cfg_ff[upbm_pkg::SEC_CODE_LSB +: 3];
  wire rb16_cfg = cfg_ff[upbm_pkg::RB16_BIT];
  wire [31:0] cfg_mask = 32'h0001_7F7F;
  wire [31:0] stat_word = {30'h0, mark_busy_ff, tx_en_ff};
  wire [31:0] rd_word = hit_cfg ? cfg_ff : (hit_stat ? stat_word : 32'h0);

  // One wait-free access: answer ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup_cyc;
      pslverr_ff <= setup_cyc & ~hit_cfg & ~hit_stat;
      prdata_ff <= (setup_cyc & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Configuration word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= upbm_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= pwdata & cfg_mask;
    end
  end

  // ----------------------------------------
  // Pilot sequence and staging
  // ----------------------------------------
  logic [11:0] prbs_ff;
  logic [11:0] sc_idx_ff;
  logic seen_ff;
  logic strobe_d_ff;
  upbm_pkg::upbm_sc_out_type out_ff;
  logic handoff_ff;

  // Fibonacci step, taps at 12, 9, 8 and 5
  wire [11:0] prbs_cur = sc_in.first ? upbm_pkg::PRBS_SEED : prbs_ff;
  wire prbs_fb = prbs_cur[11] ^ prbs_cur[8] ^ prbs_cur[7] ^ prbs_cur[4];
  wire prbs_bit = prbs_cur[11];
  wire [11:0] k_cur = sc_in.first ? 12'h000 : sc_idx_ff;
  wire sec_hit = pat_hit(k_cur, sec_start, sec_code);
  wire pri_hit = pat_hit(k_cur, pri_start, pri_code);
  // Excluded beats secondary, secondary beats primary
  wire [2:0] pat_kind = sc_in.excluded ? upbm_pkg::KIND_EXCL :
                        sec_hit ? upbm_pkg::KIND_SEC :
                        pri_hit ? upbm_pkg::KIND_PRI :
                        upbm_pkg::KIND_DATA;
  wire [2:0] st_kind = sc_in.link ? upbm_pkg::LINK_FRAME_TAG
                                  : pat_kind;
  wire [15:0] last_bit = rb16_cfg ? 16'h8000 : 16'h0080;
  wire [15:0] pri_pos = 16'h0005;
  wire [15:0] sec_pos = pri_pos | last_bit | (last_bit >> 2);
  wire pilot_blk = sc_in.link | (sc_in.burst & ~sc_in.excluded &
    (pat_kind == upbm_pkg::KIND_PRI || pat_kind == upbm_pkg::KIND_SEC));
  wire [15:0] pos_mask = (pat_kind == upbm_pkg::KIND_SEC && !sc_in.link)
                         ? sec_pos : pri_pos;
  wire [15:0] nxt_mask = pilot_blk ? pos_mask : 16'h0000;
  wire strobe_rise = frame_boundary_strobe & ~strobe_d_ff;
  wire ins_now = sc_in.valid & pilot_blk;

  // Sequence advances on every subcarrier, pilot or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prbs_ff <= upbm_pkg::PRBS_SEED;
      sc_idx_ff <= 12'h000;
    end else if (sc_in.valid) begin
      prbs_ff <= {prbs_cur[10:0], prbs_fb};
      sc_idx_ff <= k_cur + 12'h001;
    end
  end

  // Staged subcarrier; one sign serves every P slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff <= '0;
    end else begin
      out_ff.valid <= sc_in.valid;
      out_ff.first <= sc_in.first;
      out_ff.kind <= st_kind;
      out_ff.pilot_neg <= prbs_bit;
      out_ff.pilot_mask <= sc_in.valid ? nxt_mask : 16'h0000;
    end
  end

  // Frame handoff; a pilot in the edge cycle counts for the new frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_d_ff <= 1'b0;
      handoff_ff <= 1'b0;
      seen_ff <= 1'b0;
      tx_en_ff <= 1'b0;
    end else begin
      strobe_d_ff <= frame_boundary_strobe;
      handoff_ff <= strobe_rise;
      if (strobe_rise) begin
        tx_en_ff <= seen_ff;
        seen_ff <= ins_now;
      end else if (ins_now) begin
        seen_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Burst marker encoder
  // ----------------------------------------
  upbm_pkg::upbm_mark_state_type mk_state_ff;
  logic [27:0] mk_sr_ff;
  logic [4:0] mk_cnt_ff;
  logic [1:0] mk_phase_ff;
  logic mk_valid_ff;
  logic mk_ref_ff;
  upbm_pkg::upbm_mark_req_type mk_cmd_ff;

  // Info: start all ones; stop carries pad, last element, fill bit
  wire [11:0] mk_info = mark_cmd.stop
    ? {upbm_pkg::PAD_SYM, mark_cmd.last_element,
       mark_cmd.fill_bit}
    : {3{upbm_pkg::INFO_ONES}};
  wire [15:0] mk_par = rs_parity(mk_info, mark_cmd.rb16);
  // Left-aligned: symbols high first, each high pair first
  wire [27:0] mk_load = mark_cmd.rb16 ? {mk_info, mk_par}
                                      : {mk_info[7:0], mk_par, 4'h0};
  wire [4:0] mk_len = mark_cmd.rb16 ? upbm_pkg::DIBITS_RB16
                                    : upbm_pkg::DIBITS_RB8;
  localparam upbm_pkg::upbm_mark_state_type MK_IDLE_W = upbm_pkg::MK_IDLE;
  wire mk_start = mark_req & (mk_state_ff == MK_IDLE_W);
  wire [1:0] mk_dibit = mk_sr_ff[27:26];

  // Requests while busy are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mk_state_ff <= upbm_pkg::MK_IDLE;
      mk_sr_ff <= 28'h000_0000;
      mk_cnt_ff <= 5'd0;
      mk_phase_ff <= 2'h0;
      mk_valid_ff <= 1'b0;
      mk_ref_ff <= 1'b0;
      mk_cmd_ff <= '0;
    end else begin
      unique case (mk_state_ff)
        upbm_pkg::MK_IDLE: begin
          mk_valid_ff <= 1'b0;
          mk_ref_ff <= 1'b0;
          if (mk_start) begin
            mk_sr_ff <= mk_load;
            mk_cnt_ff <= mk_len;
            mk_cmd_ff <= mark_cmd;
            mk_state_ff <= upbm_pkg::MK_REF;
          end
        end
        upbm_pkg::MK_REF: begin
          mk_valid_ff <= 1'b1;
          mk_ref_ff <= 1'b1;
          mk_phase_ff <= upbm_pkg::REF_DIBIT;
          mk_state_ff <= upbm_pkg::MK_DATA;
        end
        upbm_pkg::MK_DATA: begin
          mk_ref_ff <= 1'b0;
          mk_phase_ff <= mk_phase_ff + mk_dibit;
          mk_sr_ff <= {mk_sr_ff[25:0], 2'h0};
          mk_cnt_ff <= mk_cnt_ff - 5'd1;
          if (mk_cnt_ff == 5'd1) begin
            mk_state_ff <= upbm_pkg::MK_IDLE;
          end
        end
        default: begin
          mk_state_ff <= upbm_pkg::MK_IDLE;
        end
      endcase
    end
  end

  // Length of the current element run, read by the short length check AST_LEN8 only
  logic [4:0] mk_run_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mk_run_ff <= 5'd0;
    end else begin
      mk_run_ff <= mk_valid_ff ? mk_run_ff + 5'd1 : 5'd0;
    end
  end
  // Busy flag registered beside the state for the output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mark_busy_ff <= 1'b0;
    end else begin
      mark_busy_ff <= mk_start |
        (mk_state_ff != MK_IDLE_W &&
         !(mk_state_ff == upbm_pkg::MK_DATA && mk_cnt_ff == 5'd1));
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sc_out = out_ff;
  assign frame_handoff = handoff_ff;
  assign transmit_enable_request = tx_en_ff;
  assign mark_busy = mark_busy_ff;
  assign mark_valid = mk_valid_ff;
  assign mark_ref = mk_ref_ff;
  assign mark_boost = mk_valid_ff;
  assign mark_phase = mk_phase_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SEED: assert property (@(posedge pclk) disable iff (!presetn)
    sc_in.valid && sc_in.first |=>
      prbs_ff == {upbm_pkg::PRBS_SEED[10:0], 1'b0})
    else $error("pilot sequence not seeded at subcarrier zero");
  AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    sc_in.valid && !sc_in.first |=>
      prbs_ff == {$past(prbs_ff[10:0]), $past(prbs_fb)})
    else $error("pilot sequence did not step");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !sc_in.valid |=> $stable(prbs_ff))
    else $error("pilot sequence moved without a subcarrier");
  AST_SIGN: assert property (@(posedge pclk) disable iff (!presetn)
    sc_in.valid |=> sc_out.pilot_neg == $past(prbs_cur[11]))
    else $error("pilot sign differs from sequence bit");
  AST_TAG: assert property (@(posedge pclk) disable iff (!presetn)
    sc_in.valid && sc_in.link |=>
      sc_out.kind == upbm_pkg::LINK_FRAME_TAG)
    else $error("link subcarrier not tagged");
  AST_EXCL: assert property (@(posedge pclk) disable iff (!presetn)
    sc_in.valid && sc_in.excluded && !sc_in.link |=>
      sc_out.pilot_mask == 16'h0000)
    else $error("pilot placed on excluded subcarrier");
  AST_HAND: assert property (@(posedge pclk) disable iff (!presetn)
    frame_handoff |-> $past(frame_boundary_strobe, 1) &&
      !$past(frame_boundary_strobe, 2))
    else $error("handoff without a strobe rising edge");
  AST_TXEN: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_rise |=> transmit_enable_request == $past(seen_ff))
    else $error("transmit enable disagrees with pilots seen");
  AST_REF: assert property (@(posedge pclk) disable iff (!presetn)
    mk_start |-> ##2 mark_ref && mark_phase == upbm_pkg::REF_DIBIT)
    else $error("marker reference missing");
  AST_LEN8: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(mk_valid_ff) && !$past(mk_cmd_ff.rb16) |->
      mk_run_ff == upbm_pkg::DIBITS_RB8 + 5'd1)
    else $error("short marker length wrong");
  AST_LEN16: assert property (@(posedge pclk) disable iff (!presetn)
    mk_start && mark_cmd.rb16 |-> ##16 mark_valid ##1 !mark_valid)
    else $error("long marker length wrong");
  AST_PAR: assert property (@(posedge pclk) disable iff (!presetn)
    mk_start && !mark_cmd.stop && !mark_cmd.rb16 |->
      mk_par == 16'h40D9)
    else $error("start marker parity wrong");
endmodule : upbm_top
`default_nettype wire
